// file: rtl/pll_ctrl_defines.vh
// constants for the synthesizer function and initialization latch control
`ifndef PLL_CTRL_DEFINES_VH
`define PLL_CTRL_DEFINES_VH
// ==================================================
// serial word and latch selection
`define WORD_W          24
`define SEL_REF         2'h0
`define SEL_AB          2'h1
`define SEL_FUNC        2'h2
`define SEL_INIT        2'h3
// ==================================================
// function / initialization latch field positions
`define F_CNT_RST       2
`define F_PD_REQ        3
`define F_MON_LO        4
`define F_MON_HI        6
`define F_POLARITY      7
`define F_TRISTATE      8
`define F_FL_EN         9
`define F_FL_MODE       10
`define F_TC_LO         11
`define F_TC_HI         14
`define F_CUR1_LO       15
`define F_CUR1_HI       17
`define F_CUR2_LO       18
`define F_CUR2_HI       20
`define F_PD_SYNC       21
`define F_PRE_LO        22
`define F_PRE_HI        23
// ==================================================
// gain bit inside the ab counter word
`define AB_GAIN_BIT     21
// ==================================================
// reset values and timeout scaling
`define FUNC_RST        24'h000000
`define TO_STEP         6'h04
`define TO_BASE         6'h03
`define SYNC_N          5
`endif

// file: rtl/pll_latch_ctrl.v
// control logic behind the function and initialization latches of the synthesizer
//
// Notes on behaviour
// [RULE_01] select bits 11 load the initialization latch, 10 the function latch
// [RULE_02] select bits 00 mean reference latch load, 01 mean ab latch load
// [RULE_03] counter reset bit set holds reference and ab counters in reset
// [RULE_04] clearing counter reset releases both counters together, aligned
// [RULE_05] chip enable low disables the device at once, ignoring power-down bits
// [RULE_06] power-down request with mode bit zero powers down immediately
// [RULE_07] power-down request with mode bit one waits for next pump event
// [RULE_08] any power-down loads counters, tristates pump, resets clock detect
// [RULE_09] serial input register keeps shifting and latching during power-down
// [RULE_10] three-bit select field picks the monitor output signal
// [RULE_11] fastlock is allowed only while its enable bit is one
// [RULE_12] mode bit zero selects fastlock mode 1, one selects mode 2
// [RULE_13] mode 1 uses boost current while gain bit set, exits on software clear
// [RULE_14] mode 2 clears the gain bit itself after the programmed timeout
// [RULE_15] timeout counter runs only in fastlock mode 2
// [RULE_16] pump uses normal current, or boost current while fastlock gain active
// [RULE_17] host keeps prescaler output at or below 200 MHz
// [RULE_18] pump three-state bit one tristates the pump output
// [RULE_19] a single bit sets phase detector polarity
// [RULE_20] initialization load stores settings and pulses counter reset
// [RULE_21] initialization with synchronous power-down also triggers that power-down
// [RULE_22] first ab load after initialization pulses counter reset again, later ones not
// [RULE_23] chip enable high again resumes counting aligned without reprogramming
// [RULE_24] settings change only when a whole word is latched
`default_nettype none
`include "pll_ctrl_defines.vh"

module pll_latch_ctrl (
   // clock and reset
   input  wire        clk,
   input  wire        srst,
   // three-wire serial port and chip enable pins
   input  wire        ser_clk,
   input  wire        ser_data,
   input  wire        ser_latch,
   input  wire        chip_en,
   // charge pump event from the phase detector
   input  wire        pump_event,
   // counter side
   output reg         ref_cnt_rst_ff,
   output reg         ab_cnt_rst_ff,
   output reg         ref_load_ff,
   output reg         ab_load_ff,
   output reg  [23:0] ref_word_ff,
   output reg  [23:0] ab_word_ff,
   output reg  [1:0]  prescaler_select_ff,
   // pump and detector side
   output reg  [2:0]  pump_current_ff,
   output reg         pump_tristate_ff,
   output reg         pump_polarity_ff,
   output reg         pump_gain_select_ff,
   output reg         power_down_ff,
   output reg         clk_detect_rst_ff,
   output reg  [2:0]  monitor_select_ff
);

   // ==================================================
   // pin synchronisers
   // order: latch, data, clock, chip enable, pump event
   wire [`SYNC_N-1:0] pins_raw = {pump_event, chip_en, ser_clk, ser_data, ser_latch};
   reg  [`SYNC_N-1:0] meta_ff;
   reg  [`SYNC_N-1:0] sync_ff;
   reg  [`SYNC_N-1:0] dly_ff;

   // first stage feeds only the second; third stage only for edge finding
   always @(posedge clk) begin
      if (srst) begin
         meta_ff <= {`SYNC_N{1'b0}};
         sync_ff <= {`SYNC_N{1'b0}};
         dly_ff  <= {`SYNC_N{1'b0}};
      end else begin
         meta_ff <= pins_raw;
         sync_ff <= meta_ff;
         dly_ff  <= sync_ff;
      end
   end

   wire latch_rise = sync_ff[0] & ~dly_ff[0];
   wire data_s     = sync_ff[1];
   wire sclk_rise  = sync_ff[2] & ~dly_ff[2];
   wire ce_s       = sync_ff[3];
   wire event_rise = sync_ff[4] & ~dly_ff[4];

   // ==================================================
   // serial shift register, alive in every power state
   reg  [23:0] shift_ff;

   always @(posedge clk) begin
      if (srst) begin
         shift_ff <= 24'h000000;
      end else if (sclk_rise) begin
         shift_ff <= {shift_ff[22:0], data_s};   // [RULE_09]
      end
   end

   // ==================================================
   // word decode on the latch enable edge
   function [3:0] decode_sel;
      input [1:0] sel;
      begin
         decode_sel = 4'h0;
         decode_sel[sel] = 1'b1;
      end
   endfunction

   // one-hot: bit0 ref, bit1 ab, bit2 function, bit3 init
   wire [3:0] hit = latch_rise ? decode_sel(shift_ff[1:0]) : 4'h0;   // [RULE_01] [RULE_02]

   // ==================================================
   // function settings, written only from a complete word
   reg  [23:0] func_ff;
   reg         gain_ff;
   reg         ab_armed_ff;

   always @(posedge clk) begin
      if (srst) begin
         func_ff <= `FUNC_RST;
      end else if (hit[2] | hit[3]) begin
         func_ff <= shift_ff;                    // [RULE_24] [RULE_20]
      end
   end

   // field views
   wire       f_cnt_rst = func_ff[`F_CNT_RST];
   wire       f_pd_req  = func_ff[`F_PD_REQ];
   wire       f_pd_sync = func_ff[`F_PD_SYNC];
   wire       f_fl_en   = func_ff[`F_FL_EN];
   wire       f_fl_mode = func_ff[`F_FL_MODE];
   wire [3:0] f_tc      = func_ff[`F_TC_HI:`F_TC_LO];
   wire [2:0] f_cur1    = func_ff[`F_CUR1_HI:`F_CUR1_LO];
   wire [2:0] f_cur2    = func_ff[`F_CUR2_HI:`F_CUR2_LO];

   // ==================================================
   // counter latch words and their load strobes
   always @(posedge clk) begin
      if (srst) begin
         ref_word_ff <= 24'h000000;
         ab_word_ff  <= 24'h000000;
         ref_load_ff <= 1'b0;
         ab_load_ff  <= 1'b0;
      end else begin
         ref_load_ff <= hit[0];                  // [RULE_02]
         ab_load_ff  <= hit[1];
         if (hit[0]) begin
            ref_word_ff <= shift_ff;
         end
         if (hit[1]) begin
            ab_word_ff <= shift_ff;
         end
      end
   end

   // ==================================================
   // internal reset pulse: on init, and on the first ab load after it
   reg  init_pulse;

   always @(posedge clk) begin
      if (srst) begin
         ab_armed_ff <= 1'b0;
      end else if (hit[3]) begin
         ab_armed_ff <= 1'b1;
      end else if (hit[1]) begin
         ab_armed_ff <= 1'b0;                    // [RULE_22]
      end
   end

   always @* begin
      init_pulse = hit[3] | (hit[1] & ab_armed_ff);   // [RULE_20] [RULE_22]
   end

   // ==================================================
   // power-down
   reg  sync_pd_ff;
   wire sync_mode_req = f_pd_req & f_pd_sync;
   // an init word asking for the gated mode treats its own pulse as the pump event
   wire init_sync_pd  = hit[3] & shift_ff[`F_PD_REQ] & shift_ff[`F_PD_SYNC] & ce_s;

   always @(posedge clk) begin
      if (srst) begin
         sync_pd_ff <= 1'b0;
      end else if (init_sync_pd) begin
         sync_pd_ff <= 1'b1;                     // [RULE_21]
      end else if (~sync_mode_req) begin
         sync_pd_ff <= 1'b0;
      end else if (event_rise) begin
         sync_pd_ff <= 1'b1;                     // [RULE_07]
      end
   end

   // chip enable overrides both programmed bits; release needs no reload
   wire pd_now = ~ce_s                           // [RULE_05] [RULE_23]
               | (f_pd_req & ~f_pd_sync)         // [RULE_06]
               | sync_pd_ff;

   // ==================================================
   // fastlock and its timeout counter
   localparam FL_IDLE  = 3'b001;
   localparam FL_MAN   = 3'b010;
   localparam FL_TIMED = 3'b100;

   reg  [2:0] fl_state_ff;
   reg  [2:0] nxt_fl_state;
   reg  [5:0] to_cnt_ff;
   wire [5:0] to_limit = {f_tc, 2'b00} + `TO_BASE;   // 4*tc+3 detector cycles
   wire       ab_gain  = shift_ff[`AB_GAIN_BIT];
   wire       timeout  = (fl_state_ff == FL_TIMED) & event_rise & (to_cnt_ff >= to_limit);

   // gain bit: written by ab loads, cleared by the timer in mode 2
   always @(posedge clk) begin
      if (srst) begin
         gain_ff <= 1'b0;
      end else if (hit[1]) begin
         gain_ff <= ab_gain;                     // [RULE_13]
      end else if (timeout) begin
         gain_ff <= 1'b0;                        // [RULE_14]
      end
   end

   always @* begin
      nxt_fl_state = fl_state_ff;
      case (fl_state_ff)
         FL_IDLE: begin
            if (gain_ff & f_fl_en) begin         // [RULE_11]
               nxt_fl_state = f_fl_mode ? FL_TIMED : FL_MAN;   // [RULE_12]
            end
         end
         FL_MAN: begin
            if (~gain_ff | ~f_fl_en | f_fl_mode) begin
               nxt_fl_state = FL_IDLE;           // [RULE_13]
            end
         end
         FL_TIMED: begin
            if (~gain_ff | ~f_fl_en | ~f_fl_mode) begin
               nxt_fl_state = FL_IDLE;           // [RULE_14]
            end
         end
         default: begin
            nxt_fl_state = FL_IDLE;
         end
      endcase
   end

   always @(posedge clk) begin
      if (srst) begin
         fl_state_ff <= FL_IDLE;
      end else begin
         fl_state_ff <= nxt_fl_state;
      end
   end

   // timer counts detector events, held at load state outside mode 2 or in power-down
   always @(posedge clk) begin
      if (srst) begin
         to_cnt_ff <= 6'h00;
      end else if (pd_now | (fl_state_ff != FL_TIMED)) begin
         to_cnt_ff <= 6'h00;                     // [RULE_15] [RULE_08]
      end else if (event_rise & ~timeout) begin
         to_cnt_ff <= to_cnt_ff + 6'h01;
      end
   end

   wire boost = (fl_state_ff != FL_IDLE) & gain_ff;

   // ==================================================
   // registered outputs
   always @(posedge clk) begin
      if (srst) begin
         ref_cnt_rst_ff      <= 1'b1;
         ab_cnt_rst_ff       <= 1'b1;
         power_down_ff       <= 1'b1;
         clk_detect_rst_ff   <= 1'b1;
         pump_tristate_ff    <= 1'b1;
         pump_current_ff     <= 3'h0;
         pump_polarity_ff    <= 1'b0;
         pump_gain_select_ff <= 1'b0;
         monitor_select_ff   <= 3'h0;
         prescaler_select_ff <= 2'h0;
      end else begin
         // both counters share one term so they leave reset in the same cycle
         ref_cnt_rst_ff      <= f_cnt_rst | pd_now | init_pulse;   // [RULE_03] [RULE_04] [RULE_08]
         ab_cnt_rst_ff       <= f_cnt_rst | pd_now | init_pulse;   // [RULE_03] [RULE_04] [RULE_08]
         power_down_ff       <= pd_now;
         clk_detect_rst_ff   <= pd_now;                            // [RULE_08]
         pump_tristate_ff    <= func_ff[`F_TRISTATE] | pd_now      // [RULE_18] [RULE_08]
                              | f_cnt_rst | init_pulse;
         pump_current_ff     <= boost ? f_cur2 : f_cur1;           // [RULE_16]
         pump_polarity_ff    <= func_ff[`F_POLARITY];              // [RULE_19]
         pump_gain_select_ff <= gain_ff;
         monitor_select_ff   <= func_ff[`F_MON_HI:`F_MON_LO];      // [RULE_10]
         prescaler_select_ff <= func_ff[`F_PRE_HI:`F_PRE_LO];      // [RULE_17]
      end
   end

endmodule // pll_latch_ctrl
`default_nettype wire

// file: sim/pll_latch_ctrl_checker.sv
// assertions on the latch control block ports
`default_nettype none
module pll_latch_ctrl_checker (
   // clock, reset and chip enable pin
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        chip_en,
   // outputs watched
   input wire logic        ref_cnt_rst_ff,
   input wire logic        ab_cnt_rst_ff,
   input wire logic        ref_load_ff,
   input wire logic        ab_load_ff,
   input wire logic [23:0] ref_word_ff,
   input wire logic [23:0] ab_word_ff,
   input wire logic        pump_tristate_ff,
   input wire logic        pump_gain_select_ff,
   input wire logic        power_down_ff,
   input wire logic        clk_detect_rst_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ==========
   // power-down; two sync stages plus one register allowed
   chk_ce_down: assert property (!chip_en [*4] |-> power_down_ff)
      else $error("chip enable low without power-down");
   chk_pd_effects: assert property (power_down_ff && $past(power_down_ff)
      |-> pump_tristate_ff && clk_detect_rst_ff && ref_cnt_rst_ff)
      else $error("power-down side effects missing");
   chk_rst_pair: assert property (ref_cnt_rst_ff == ab_cnt_rst_ff)
      else $error("counter resets differ");
   // ==========
   // loads
   chk_ref_pulse: assert property (ref_load_ff |=> !ref_load_ff)
      else $error("reference load pulse too long");
   chk_ab_pulse: assert property (ab_load_ff |=> !ab_load_ff)
      else $error("ab load pulse too long");
   chk_ref_word: assert property (!$stable(ref_word_ff) |-> ref_load_ff)
      else $error("reference word changed without load");
   chk_ab_word: assert property (!$stable(ab_word_ff) |-> ab_load_ff)
      else $error("ab word changed without load");
   chk_gain_cause: assert property ($rose(pump_gain_select_ff) |-> ab_word_ff[21])
      else $error("gain set without gain bit");
endmodule // pll_latch_ctrl_checker
bind pll_latch_ctrl pll_latch_ctrl_checker pll_latch_ctrl_checker_inst (.clk, .srst,
   .chip_en, .ref_cnt_rst_ff, .ab_cnt_rst_ff, .ref_load_ff, .ab_load_ff, .ref_word_ff,
   .ab_word_ff, .pump_tristate_ff, .pump_gain_select_ff, .power_down_ff, .clk_detect_rst_ff);
`default_nettype wire

// file: sim/ser_host.sv
// host model shifting words into the serial port
`default_nettype none
module ser_host (
   // serial pins toward the device
   output var logic ser_clk,
   output var logic ser_data,
   output var logic ser_latch
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_latch = 1'b0;
   end
   // msb first, 160 ns link clock, still between frames
   task automatic send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         ser_data = w[i];
         #80 ser_clk = 1'b1;
         #80 ser_clk = 1'b0;
      end
      ser_data = ~ser_data; // released line shows no stale bit
      #80 ser_latch = 1'b1;
      #80 ser_latch = 1'b0;
   endtask
endmodule // ser_host
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the latch control block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // pins and bookkeeping
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        chip_en = 1'b0;
   logic        pump_event = 1'b0;
   logic [23:0] f;
   logic [23:0] w;
   int          n_rst = 0;
   int          n_rld = 0;
   int          n_ald = 0;
   int          base = 0;
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          seed = 32'h847a;
   wire         sck, sda, sle, rrst, arst, rld, ald, tri_st, pol, gain, pd, cdr;
   wire  [23:0] rword, aword;
   wire  [2:0]  cur, mon;
   wire  [1:0]  pre;
   always #5 clk = ~clk;
   // running counts of counter reset cycles and load strobes, one driver each
   always @(posedge clk) begin
      if (rrst) n_rst <= n_rst + 1;
      if (rld) n_rld <= n_rld + 1;
      if (ald) n_ald <= n_ald + 1;
   end
   pll_latch_ctrl pll_latch_ctrl_inst (.clk(clk), .srst(srst), .ser_clk(sck),
      .ser_data(sda), .ser_latch(sle), .chip_en(chip_en), .pump_event(pump_event),
      .ref_cnt_rst_ff(rrst), .ab_cnt_rst_ff(arst), .ref_load_ff(rld), .ab_load_ff(ald),
      .ref_word_ff(rword), .ab_word_ff(aword), .prescaler_select_ff(pre),
      .pump_current_ff(cur), .pump_tristate_ff(tri_st), .pump_polarity_ff(pol),
      .pump_gain_select_ff(gain), .power_down_ff(pd), .clk_detect_rst_ff(cdr),
      .monitor_select_ff(mon));
   ser_host ser_host_inst (.ser_clk(sck), .ser_data(sda), .ser_latch(sle));
   // ==========
   // helpers
   function automatic logic [23:0] mk(input logic [31:0] r, input logic [1:0] s);
      mk = {r[23:2], s};
   endfunction
   function automatic logic [23:0] exp_cur(input logic [23:0] w, input logic g);
      exp_cur = {21'h0, g ? w[20:18] : w[17:15]};
   endfunction
   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_vec(input string nm, input logic [23:0] e, input logic [23:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // whole word then a settle margin past the five cycle answer
   task automatic load(input logic [23:0] w);
      ser_host_inst.send(w);
      repeat (2) @(negedge clk);
   endtask
   task automatic pulse(input int k);
      repeat (k) begin
         pump_event = 1'b1;
         repeat (4) @(negedge clk);
         pump_event = 1'b0;
         repeat (4) @(negedge clk);
      end
   endtask
   task automatic wrap_up();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ==========
   // scenarios
   initial begin
      repeat (6) @(negedge clk);
      srst = 1'b0;
      chip_en = 1'b1;
      repeat (6) @(negedge clk);
      repeat (3) begin
         f = mk($random(seed), 2'h0);
         load(f);
         chk_vec("ref_word", f, rword);
         f = mk($random(seed), 2'h1) & 24'hdfffff;
         load(f);
         chk_vec("ab_word", f, aword);
         // no reset, power-down, fastlock or sync bits
         // prescaler left random: rf input not modelled, host limit only
         f = mk($random(seed), 2'h2) & 24'hdffdf3;
         load(f);
         chk_vec("fields", {17'h0, f[23:22], f[8:4]}, {17'h0, pre, tri_st, pol, mon});
         chk_vec("current", exp_cur(f, 1'b0), {21'h0, cur});
      end
      load(f | 24'h4);
      chk_bit("cnt_rst", 1'b1, rrst);
      chk_bit("ab_cnt_rst", 1'b1, arst);
      load(f);
      chk_bit("cnt_rst", 1'b0, rrst);
      $display("test words done");
      chip_en = 1'b0;
      repeat (4) @(negedge clk);
      chk_bit("power_down", 1'b1, pd);
      chk_bit("clk_detect", 1'b1, cdr);
      w = mk($random(seed), 2'h0);
      load(w);
      chk_vec("ref_word_pd", w, rword);
      chip_en = 1'b1;
      repeat (4) @(negedge clk);
      chk_bit("power_down", 1'b0, pd);
      load(f | 24'h8);
      chk_bit("power_down", 1'b1, pd);
      load(f);
      load(f | 24'h200008);
      chk_bit("power_down", 1'b0, pd);
      pulse(1);
      chk_bit("power_down", 1'b1, pd);
      chk_bit("tristate", 1'b1, tri_st);
      load(f);
      $display("test power done");
      // timed fastlock with shortest timeout field
      f = (f & 24'hff87ff) | 24'h600;
      load(f);
      load(mk($random(seed), 2'h1) | 24'h200000);
      chk_vec("current", exp_cur(f, 1'b1), {21'h0, cur});
      pulse(3);
      chk_bit("gain", 1'b1, gain);
      pulse(1);
      chk_bit("gain", 1'b0, gain);
      chk_vec("current", exp_cur(f, 1'b0), {21'h0, cur});
      f = f & 24'hfffbff;
      load(f);
      load(mk($random(seed), 2'h1) | 24'h200000);
      pulse(8);
      chk_bit("gain", 1'b1, gain);
      chk_vec("current", exp_cur(f, 1'b1), {21'h0, cur});
      load(mk($random(seed), 2'h1) & 24'hdfffff);
      chk_bit("gain", 1'b0, gain);
      f = f & 24'hfffdff;
      load(f);
      load(mk($random(seed), 2'h1) | 24'h200000);
      chk_vec("current", exp_cur(f, 1'b0), {21'h0, cur});
      load(mk($random(seed), 2'h1) & 24'hdfffff);
      $display("test fastlock done");
      f = mk($random(seed), 2'h3) & 24'hdffdf3;
      base = n_rst;
      load(f);
      chk_bit("init_pulse", 1'b1, n_rst != base);
      chk_vec("monitor", {21'h0, f[6:4]}, {21'h0, mon});
      base = n_rst;
      load(mk($random(seed), 2'h1) & 24'hdfffff);
      chk_bit("ab_pulse", 1'b1, n_rst != base);
      base = n_rst;
      load(mk($random(seed), 2'h1) & 24'hdfffff);
      chk_bit("ab_pulse", 1'b0, n_rst != base);
      // init word asking for gated power-down enters it with no pump event
      load(f | 24'h200008);
      chk_bit("init_sync_pd", 1'b1, pd);
      // every counter latch word gives exactly one load strobe
      chk_vec("ref_loads", 24'h4, n_rld[23:0]);
      chk_vec("ab_loads", 24'ha, n_ald[23:0]);
      $display("test init done");
      wrap_up();
   end
   // watchdog at several times the expected run of about 120 microseconds
   initial begin
      #900000;
      n_mismatch++;
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
